// ---- inc/adc_cfg_pkg.sv ----
// Register map, field layout, reset values and types of the ADC config bank.
// Assumes a 13-bit register address space reached over a three-wire serial port.
package adc_cfg_pkg;

	// ==================================================================
	// Addresses
	localparam int ADDR_W = 13;
	localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
	localparam logic [12:0] ADDR_PART_ID = 13'h001;
	localparam logic [12:0] ADDR_SPEED = 13'h002;
	localparam logic [12:0] ADDR_MODES = 13'h008;
	localparam logic [12:0] ADDR_CLOCK = 13'h009;
	localparam logic [12:0] ADDR_TEST = 13'h00d;
	localparam logic [12:0] ADDR_OFFSET = 13'h010;
	localparam logic [12:0] ADDR_OUT_MODE = 13'h014;
	localparam logic [12:0] ADDR_OUT_PHASE = 13'h016;
	localparam logic [12:0] ADDR_VREF = 13'h018;
	localparam logic [12:0] ADDR_TRANSFER = 13'h0ff;

	// ==================================================================
	// Reset values
	localparam logic [7:0] RST_PORT_CFG = 8'h18;
	localparam logic [7:0] RST_MODES = 8'h00;
	localparam logic [7:0] RST_CLOCK = 8'h01;
	localparam logic [7:0] RST_TEST = 8'h00;
	localparam logic [7:0] RST_OFFSET = 8'h00;
	localparam logic [7:0] RST_OUT_MODE = 8'h00;
	localparam logic [7:0] RST_OUT_PHASE = 8'h00;
	localparam logic [7:0] RST_VREF = 8'hc0;

	// ==================================================================
	// Shadow bank slots, index 0 in the low byte
	localparam int SH_DEPTH = 7;
	localparam int SH_IDX_W = 3;
	localparam int SH_MODES = 0;
	localparam int SH_CLOCK = 1;
	localparam int SH_TEST = 2;
	localparam int SH_OFFSET = 3;
	localparam int SH_OUT_MODE = 4;
	localparam int SH_OUT_PHASE = 5;
	localparam int SH_VREF = 6;
	localparam logic [55:0] SH_INIT = {RST_VREF, RST_OUT_PHASE,
		RST_OUT_MODE, RST_OFFSET, RST_TEST, RST_CLOCK, RST_MODES};
	// Open bits are dropped on write so they read back as zero
	localparam logic [55:0] SH_MASK = 56'hc0_80_d7_3f_37_01_27;

	// ==================================================================
	// Field positions
	localparam int PORT_LSB_FIRST = 6;
	localparam int PORT_SOFT_RESET = 5;
	localparam int GRADE_BIT = 3;
	localparam int TRANSFER_BIT = 0;
	localparam int PWR_PIN_STANDBY = 5;
	localparam int DCS_BIT = 0;
	localparam int PN23_RESET = 5;
	localparam int PN9_RESET = 4;
	localparam int OUT_DRIVE = 6;
	localparam int OUT_DISABLE = 4;
	localparam int OUT_INVERT = 2;
	localparam int DCO_INVERT = 7;
	localparam int VREF_SEL = 6;
	localparam int INSTR_BITS = 16;
	localparam int INSTR_READ = 15;

	// ==================================================================
	// Codes and output patterns
	localparam logic [2:0] PWR_CODE_OFF = 3'h1;
	localparam logic [2:0] PWR_CODE_STANDBY = 3'h2;
	localparam logic [2:0] TEST_OFF = 3'h0;
	localparam logic [2:0] TEST_MIDSCALE = 3'h1;
	localparam logic [2:0] TEST_POS_FS = 3'h2;
	localparam logic [2:0] TEST_NEG_FS = 3'h3;
	localparam logic [2:0] TEST_CHECKER = 3'h4;
	localparam logic [2:0] TEST_PN23 = 3'h5;
	localparam logic [2:0] TEST_PN9 = 3'h6;
	localparam logic [1:0] FMT_TWOS = 2'h1;
	localparam logic [1:0] FMT_GRAY = 2'h2;
	localparam logic [11:0] PAT_MIDSCALE = 12'h800;
	localparam logic [11:0] PAT_POS_FS = 12'hfff;
	localparam logic [11:0] PAT_NEG_FS = 12'h000;
	localparam logic [11:0] PAT_CHECK_A = 12'h555;
	localparam logic [11:0] PAT_CHECK_B = 12'haaa;

	typedef enum logic [1:0] {PWR_NORMAL, PWR_STANDBY, PWR_OFF} power_e;
	typedef enum logic [1:0] {COPY_IDLE, COPY_RUN, COPY_DONE} copy_e;

	typedef struct packed {
		power_e power;
		logic dcs_enable;
		logic [5:0] offset_trim;
		logic [2:0] test_mode;
		logic [1:0] drive_strength;
		logic output_disable;
		logic data_invert;
		logic [1:0] data_format;
		logic dco_invert;
		logic [1:0] vref_select;
	} adc_config_s;

endpackage : adc_cfg_pkg

// ---- hdl/shadow_bank.sv ----
// Shadow byte store written by the serial port, two registered read ports.
// Assumes one clock domain; clear restores every slot to its default.
`timescale 1ns/1ps
module shadow_bank
	import adc_cfg_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = SH_DEPTH,
	parameter int IDX_W = SH_IDX_W,
	parameter logic [WIDTH*DEPTH-1:0] INIT = SH_INIT
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [IDX_W-1:0] rd_a_idx,
	output logic [WIDTH-1:0] rd_a_data,
	input wire logic [IDX_W-1:0] rd_b_idx,
	output logic [WIDTH-1:0] rd_b_data
);

	// ==================================================================
	// Storage
	logic [WIDTH*DEPTH-1:0] mem;
	logic [WIDTH*DEPTH-1:0] next_mem;

	always_comb
	begin
		next_mem = mem;
		if (clear)
			next_mem = INIT;
		else if (wr_en && int'(wr_idx) < DEPTH)
			next_mem[int'(wr_idx)*WIDTH +: WIDTH] = wr_data;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			mem <= INIT;
			rd_a_data <= '0;
			rd_b_data <= '0;
		end
		else
		begin
			mem <= next_mem;
			rd_a_data <= (int'(rd_a_idx) < DEPTH) ?
				mem[int'(rd_a_idx)*WIDTH +: WIDTH] : '0;
			rd_b_data <= (int'(rd_b_idx) < DEPTH) ?
				mem[int'(rd_b_idx)*WIDTH +: WIDTH] : '0;
		end
	end

endmodule : shadow_bank

// ---- hdl/adc_serial_config.sv ----
// Serial-port configuration bank of a pipelined ADC and its output stage.
// Assumes pins from an external serial host, sampled by the 100 MHz clock.
`timescale 1ns/1ps
module adc_serial_config
	import adc_cfg_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
	parameter logic SPEED_GRADE = 1'b0
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	input wire logic power_down_pin,
	input wire logic [13:0] conv_fine,
	input wire logic conv_valid,
	output logic [11:0] out_data,
	output logic output_data_clock,
	output logic output_enable,
	output adc_config_s config_out
);

	// ==================================================================
	// Functions
	function automatic logic [3:0] slot_of(input logic [12:0] a);
		case (a)
			ADDR_MODES: return {1'b1, 3'(SH_MODES)};
			ADDR_CLOCK: return {1'b1, 3'(SH_CLOCK)};
			ADDR_TEST: return {1'b1, 3'(SH_TEST)};
			ADDR_OFFSET: return {1'b1, 3'(SH_OFFSET)};
			ADDR_OUT_MODE: return {1'b1, 3'(SH_OUT_MODE)};
			ADDR_OUT_PHASE: return {1'b1, 3'(SH_OUT_PHASE)};
			ADDR_VREF: return {1'b1, 3'(SH_VREF)};
			default: return 4'h0;
		endcase
	endfunction : slot_of

	function automatic logic [7:0] byte_of(input logic [55:0] v,
		input int i);
		return v[i*8 +: 8];
	endfunction : byte_of

	// ==================================================================
	// Pin synchronisers; a level counts once stages two and three agree
	logic [2:0] sclk_s, csn_s, sdio_s, power_down_pin_s;
	logic sclk_f, csn_f, sdio_f, power_down_pin_f, sclk_prev;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_s <= 3'h0;
			csn_s <= 3'h7;
			sdio_s <= 3'h0;
			power_down_pin_s <= 3'h0;
			sclk_f <= 1'b0;
			csn_f <= 1'b1;
			sdio_f <= 1'b0;
			power_down_pin_f <= 1'b0;
			sclk_prev <= 1'b0;
		end
		else
		begin
			sclk_s <= {sclk_s[1:0], sclk};
			csn_s <= {csn_s[1:0], chip_select_n};
			sdio_s <= {sdio_s[1:0], sdio_in};
			power_down_pin_s <= {power_down_pin_s[1:0], power_down_pin};
			if (sclk_s[1] == sclk_s[2]) sclk_f <= sclk_s[2];
			if (csn_s[1] == csn_s[2]) csn_f <= csn_s[2];
			if (sdio_s[1] == sdio_s[2]) sdio_f <= sdio_s[2];
			if (power_down_pin_s[1] == power_down_pin_s[2]) power_down_pin_f <= power_down_pin_s[2];
			sclk_prev <= sclk_f;
		end
	end

	wire logic sclk_rise = sclk_f & ~sclk_prev;
	wire logic sclk_fall = ~sclk_f & sclk_prev;

	// ==================================================================
	// Serial engine
	// Frame length bits are ignored: the frame streams until select rises
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [2:0] byte_bit, next_byte_bit;
	logic [15:0] instr, next_instr;
	logic [7:0] data_sh, next_data_sh;
	logic [12:0] addr, next_addr;
	logic is_read, next_is_read, next_sdio_out, next_sdio_oe;
	logic [7:0] port_cfg, next_port_cfg, rd_byte;
	logic wr_byte_en, soft_clear, set_transfer, lsb_first;
	logic [7:0] wr_byte;
	logic [3:0] wr_slot, rd_slot;
	logic [7:0] rd_a_data, rd_b_data;
	logic transfer;

	assign lsb_first = port_cfg[PORT_LSB_FIRST];
	assign wr_slot = slot_of(addr);
	assign rd_slot = slot_of(addr);

	always_comb
	begin
		next_bit_cnt = bit_cnt;
		next_byte_bit = byte_bit;
		next_instr = instr;
		next_data_sh = data_sh;
		next_addr = addr;
		next_is_read = is_read;
		next_sdio_out = sdio_out;
		next_sdio_oe = sdio_oe;
		wr_byte_en = 1'b0;
		wr_byte = 8'h00;
		if (csn_f)
		begin
			next_bit_cnt = 5'h00;
			next_byte_bit = 3'h0;
			next_sdio_oe = 1'b0;
		end
		else if (sclk_rise && bit_cnt < 5'(INSTR_BITS))
		begin
			next_instr = lsb_first ? {sdio_f, instr[15:1]} :
				{instr[14:0], sdio_f};
			next_bit_cnt = bit_cnt + 5'h01;
			if (bit_cnt == 5'(INSTR_BITS - 1))
			begin
				next_addr = next_instr[12:0];
				next_is_read = next_instr[INSTR_READ];
			end
		end
		else if (sclk_rise)
		begin
			next_data_sh = lsb_first ? {sdio_f, data_sh[7:1]} :
				{data_sh[6:0], sdio_f};
			next_byte_bit = byte_bit + 3'h1;
			if (byte_bit == 3'h7)
			begin
				wr_byte_en = ~is_read;
				wr_byte = next_data_sh;
				next_addr = lsb_first ? addr + 13'h001 : addr - 13'h001;
			end
		end
		else if (sclk_fall && is_read && bit_cnt == 5'(INSTR_BITS))
		begin
			next_sdio_oe = 1'b1;
			next_sdio_out = lsb_first ? rd_byte[byte_bit] :
				rd_byte[3'h7 - byte_bit];
		end
	end

	// Soft reset restores defaults and clears itself
	always_comb
	begin
		next_port_cfg = port_cfg;
		soft_clear = 1'b0;
		set_transfer = 1'b0;
		if (wr_byte_en && addr == ADDR_PORT_CFG)
		begin
			// Low nibble mirrors the high one bit-reversed
			next_port_cfg = {1'b0, wr_byte[6:5], 2'h3, wr_byte[5],
				wr_byte[6], 1'b0};
			if (wr_byte[PORT_SOFT_RESET])
			begin
				soft_clear = 1'b1;
				next_port_cfg = RST_PORT_CFG;
			end
		end
		if (wr_byte_en && addr == ADDR_TRANSFER)
			set_transfer = wr_byte[TRANSFER_BIT];
	end

	always_comb
	begin
		case (addr)
			ADDR_PORT_CFG: rd_byte = port_cfg;
			ADDR_PART_ID: rd_byte = PART_ID;
			ADDR_SPEED: rd_byte = 8'({SPEED_GRADE} << GRADE_BIT);
			ADDR_TRANSFER: rd_byte = {7'h00, transfer};
			default: rd_byte = rd_slot[3] ? rd_a_data : 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			bit_cnt <= 5'h00;
			byte_bit <= 3'h0;
			instr <= 16'h0000;
			data_sh <= 8'h00;
			addr <= 13'h0000;
			is_read <= 1'b0;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
			port_cfg <= RST_PORT_CFG;
		end
		else
		begin
			bit_cnt <= next_bit_cnt;
			byte_bit <= next_byte_bit;
			instr <= next_instr;
			data_sh <= next_data_sh;
			addr <= next_addr;
			is_read <= next_is_read;
			sdio_out <= next_sdio_out;
			sdio_oe <= next_sdio_oe;
			port_cfg <= next_port_cfg;
		end
	end

	// ==================================================================
	// Shadow store and transfer into the active copy
	copy_e copy_state, next_copy_state;
	logic [2:0] copy_idx, next_copy_idx, load_idx, next_load_idx;
	logic load_pend, next_load_pend, next_transfer, clear_transfer;
	logic [55:0] active, next_active;

	shadow_bank bank (
		.clock(clock),
		.resetn(resetn),
		.clear(soft_clear),
		.wr_en(wr_byte_en & wr_slot[3]),
		.wr_idx(wr_slot[2:0]),
		.wr_data(wr_byte & byte_of(SH_MASK, int'(wr_slot[2:0]))),
		.rd_a_idx(rd_slot[2:0]),
		.rd_a_data(rd_a_data),
		.rd_b_idx(copy_idx),
		.rd_b_data(rd_b_data)
	);

	always_comb
	begin
		next_copy_state = copy_state;
		next_copy_idx = copy_idx;
		next_load_pend = 1'b0;
		next_load_idx = copy_idx;
		next_active = active;
		clear_transfer = 1'b0;
		case (copy_state)
			COPY_IDLE:
				if (transfer)
				begin
					next_copy_state = COPY_RUN;
					next_copy_idx = 3'h0;
				end
			COPY_RUN:
			begin
				next_load_pend = 1'b1;
				if (copy_idx == 3'(SH_DEPTH - 1))
					next_copy_state = COPY_DONE;
				else
					next_copy_idx = copy_idx + 3'h1;
			end
			COPY_DONE:
			begin
				clear_transfer = 1'b1;
				next_copy_state = COPY_IDLE;
			end
			default: next_copy_state = COPY_IDLE;
		endcase
		if (load_pend)
			next_active[int'(load_idx)*8 +: 8] = rd_b_data;
		// A new request in the clearing cycle is kept
		next_transfer = (transfer & ~clear_transfer) | set_transfer;
		if (soft_clear)
		begin
			next_active = SH_INIT;
			next_transfer = 1'b0;
			next_copy_state = COPY_IDLE;
			next_load_pend = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			copy_state <= COPY_IDLE;
			copy_idx <= 3'h0;
			load_idx <= 3'h0;
			load_pend <= 1'b0;
			transfer <= 1'b0;
			active <= SH_INIT;
		end
		else
		begin
			copy_state <= next_copy_state;
			copy_idx <= next_copy_idx;
			load_idx <= next_load_idx;
			load_pend <= next_load_pend;
			transfer <= next_transfer;
			active <= next_active;
		end
	end

	// ==================================================================
	// Active configuration
	adc_config_s next_cfg;
	logic [7:0] modes_b, out_mode_b;

	always_comb
	begin
		modes_b = byte_of(active, SH_MODES);
		out_mode_b = byte_of(active, SH_OUT_MODE);
		next_cfg.power = PWR_NORMAL;
		if (modes_b[2:0] == PWR_CODE_OFF)
			next_cfg.power = PWR_OFF;
		else if (modes_b[2:0] == PWR_CODE_STANDBY)
			next_cfg.power = PWR_STANDBY;
		if (power_down_pin_f)
			next_cfg.power = modes_b[PWR_PIN_STANDBY] ?
				PWR_STANDBY : PWR_OFF;
		next_cfg.dcs_enable = active[SH_CLOCK*8 + DCS_BIT];
		next_cfg.offset_trim = active[SH_OFFSET*8 +: 6];
		next_cfg.test_mode = active[SH_TEST*8 +: 3];
		next_cfg.drive_strength = out_mode_b[OUT_DRIVE +: 2];
		next_cfg.output_disable = out_mode_b[OUT_DISABLE];
		next_cfg.data_invert = out_mode_b[OUT_INVERT];
		next_cfg.data_format = out_mode_b[1:0];
		next_cfg.dco_invert = active[SH_OUT_PHASE*8 + DCO_INVERT];
		next_cfg.vref_select = active[SH_VREF*8 + VREF_SEL +: 2];
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			config_out <= '{PWR_NORMAL, 1'b1, 6'h00, 3'h0, 2'h0,
				1'b0, 1'b0, 2'h0, 1'b0, 2'h3};
		else
			config_out <= next_cfg;
	end

	// ==================================================================
	// Output stage
	// Trim works on two fraction bits below the output LSB
	logic [11:0] next_out_data, trimmed, word;
	logic [22:0] pn23, next_pn23;
	logic [8:0] pn9, next_pn9;
	logic phase, next_phase, dco_raw, next_dco_raw;
	logic signed [15:0] sum;

	always_comb
	begin
		sum = $signed({2'b00, conv_fine}) +
			$signed({{10{config_out.offset_trim[5]}},
			config_out.offset_trim});
		if (sum < 0)
			trimmed = 12'h000;
		else if (sum > 16'sh3fff)
			trimmed = 12'hfff;
		else
			trimmed = sum[13:2];
		word = trimmed;
		if (config_out.data_format == FMT_TWOS)
			word = {~trimmed[11], trimmed[10:0]};
		else if (config_out.data_format == FMT_GRAY)
			word = trimmed ^ (trimmed >> 1);
		if (config_out.data_invert)
			word = ~word;
		case (config_out.test_mode)
			TEST_OFF: next_out_data = word;
			TEST_MIDSCALE: next_out_data = PAT_MIDSCALE;
			TEST_POS_FS: next_out_data = PAT_POS_FS;
			TEST_NEG_FS: next_out_data = PAT_NEG_FS;
			TEST_CHECKER: next_out_data = phase ? PAT_CHECK_B : PAT_CHECK_A;
			TEST_PN23: next_out_data = pn23[11:0];
			TEST_PN9: next_out_data = {pn9, pn9[8:6]};
			default: next_out_data = phase ? PAT_POS_FS : PAT_NEG_FS;
		endcase
		next_pn23 = pn23;
		next_pn9 = pn9;
		next_phase = phase;
		next_dco_raw = 1'b1;
		if (conv_valid)
		begin
			next_pn23 = {pn23[21:0], pn23[22] ^ pn23[17]};
			next_pn9 = {pn9[7:0], pn9[8] ^ pn9[4]};
			next_phase = ~phase;
			next_dco_raw = 1'b0;
		end
		else
			next_out_data = out_data;
		if (active[SH_TEST*8 + PN23_RESET])
			next_pn23 = '1;
		if (active[SH_TEST*8 + PN9_RESET])
			next_pn9 = '1;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			out_data <= 12'h000;
			pn23 <= '1;
			pn9 <= '1;
			phase <= 1'b0;
			dco_raw <= 1'b1;
		end
		else
		begin
			out_data <= next_out_data;
			pn23 <= next_pn23;
			pn9 <= next_pn9;
			phase <= next_phase;
			dco_raw <= next_dco_raw;
		end
	end

	// Polarity flips the valid edge from rising to falling
	assign output_data_clock = dco_raw ^ config_out.dco_invert;
	assign output_enable = ~config_out.output_disable;

	// ==================================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_pin_overrides: assert property (power_down_pin_f && !modes_b[PWR_PIN_STANDBY]
		|=> config_out.power == PWR_OFF)
		else $error("power pin did not force power-down");
	a_standby_decode: assert property (!power_down_pin_f &&
		modes_b[2:0] == PWR_CODE_STANDBY |=> config_out.power == PWR_STANDBY)
		else $error("standby code not decoded");
	a_normal_decode: assert property (!power_down_pin_f && modes_b[2:0] == 3'h3
		|=> config_out.power == PWR_NORMAL)
		else $error("code three not decoded as normal");
	a_transfer_ends: assert property ($rose(transfer) |-> ##[1:12] !transfer)
		else $error("transfer bit not cleared after copy");
	a_active_holds: assert property (copy_state == COPY_IDLE && !load_pend &&
		!soft_clear |=> $stable(active))
		else $error("active registers changed without transfer");
	a_soft_defaults: assert property (soft_clear |=> active == SH_INIT &&
		port_cfg == RST_PORT_CFG)
		else $error("soft reset did not restore defaults");
	a_data_at_edge: assert property (!config_out.dco_invert &&
		$rose(output_data_clock) |-> $stable(out_data))
		else $error("data changed at output clock rising edge");
	a_midscale_test: assert property (config_out.test_mode == TEST_MIDSCALE
		&& conv_valid |=> out_data == PAT_MIDSCALE)
		else $error("midscale pattern missing");
	a_dcs_follows: assert property (load_pend && load_idx == 3'(SH_CLOCK)
		|=> ##1 config_out.dcs_enable == $past(rd_b_data[DCS_BIT], 2))
		else $error("stabilizer enable not taken from clock register");

endmodule : adc_serial_config

// ---- tb/spi_host_model.sv ----
// Serial host model: one instruction and one data byte per frame.
// Assumes the bench resolves the data wire from host and device drives.
`timescale 1ns/1ps
module spi_host_model
(
	output logic sclk,
	output logic chip_select_n,
	output logic sdio_host,
	input wire logic sdio_wire
);
	logic lsb_first;
	initial
	begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		sdio_host = 1'b0;
		lsb_first = 1'b0;
	end
	// ==================================================================
	// Frame; serial clock stands low between frames
	task automatic xfer(input logic rd, input logic [12:0] addr,
		input logic [7:0] wdata, output logic [7:0] rdata);
		logic [15:0] instr;
		int j;
		instr = {rd, 2'b00, addr};
		rdata = 8'h00;
		chip_select_n = 1'b0;
		for (int k = 0; k < 24; k++)
		begin
			j = (k < 16) ? (lsb_first ? k : 15 - k) : (lsb_first ? k - 16 : 23 - k);
			if (k < 16)
				sdio_host = instr[j];
			else if (!rd)
				sdio_host = wdata[j];
			else
				sdio_host = ~sdio_host;
			#62.5 sclk = 1'b1;
			if (rd && k >= 16)
				rdata[j] = sdio_wire;
			#62.5 sclk = 1'b0;
		end
		#62.5 chip_select_n = 1'b1;
		// Released line toggles so a stale bit is never mistaken for data
		sdio_host = ~sdio_host;
		#250;
	endtask : xfer
endmodule : spi_host_model

// ---- tb/adc_serial_config_tb.sv ----
// Self-checking bench of the ADC config bank through its serial port.
// Assumes the host model frames; bench drives the rest at falling edges.
`timescale 1ns/1ps
module adc_serial_config_tb;
	import adc_cfg_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic sclk, chip_select_n, sdio_host, sdio_out, sdio_oe;
	logic power_down_pin = 1'b0;
	logic [13:0] conv_fine = 14'h0000;
	logic conv_valid = 1'b0;
	logic [11:0] out_data;
	logic output_data_clock, output_enable;
	adc_config_s config_out;
	wire logic sdio_wire = sdio_oe ? sdio_out : sdio_host;
	int bad_count = 0;
	int tests_run = 0;
	logic [7:0] d;
	logic [12:0] ra [12] = '{13'h000, 13'h001, 13'h002, 13'h003, 13'h008,
		13'h009, 13'h00d, 13'h010, 13'h014, 13'h016, 13'h018, 13'h0ff};
	logic [7:0] rv [12] = '{8'h18, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};
	power_e pexp [4] = '{PWR_NORMAL, PWR_OFF, PWR_STANDBY, PWR_NORMAL};
	logic [11:0] texp [3] = '{12'h800, 12'hfff, 12'h000};

	always #5 clock = ~clock;

	spi_host_model host (
		.sclk(sclk),
		.chip_select_n(chip_select_n),
		.sdio_host(sdio_host),
		.sdio_wire(sdio_wire)
	);

	adc_serial_config dut (
		.clock(clock),
		.resetn(resetn),
		.sclk(sclk),
		.chip_select_n(chip_select_n),
		.sdio_in(sdio_wire),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe),
		.power_down_pin(power_down_pin),
		.conv_fine(conv_fine),
		.conv_valid(conv_valid),
		.out_data(out_data),
		.output_data_clock(output_data_clock),
		.output_enable(output_enable),
		.config_out(config_out)
	);

	// ==================================================================
	// Compare, access and closing tasks
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected byte at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected word at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic wr(input logic [12:0] a, input logic [7:0] v);
		logic [7:0] x;
		host.xfer(1'b0, a, v, x);
	endtask : wr

	task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
		logic [7:0] x;
		host.xfer(1'b1, a, 8'h00, x);
		chk_reg(x, e);
	endtask : rd_chk

	// Shadow copy finishes within about ten clocks
	task automatic commit;
		wr(ADDR_TRANSFER, 8'h01);
		repeat (20) @(negedge clock);
	endtask : commit

	task automatic conv(input logic [13:0] f, input logic [11:0] e);
		@(negedge clock);
		conv_fine = f;
		conv_valid = 1'b1;
		@(negedge clock);
		conv_valid = 1'b0;
		repeat (2) @(negedge clock);
		chk_word(out_data, e);
	endtask : conv

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	initial
	begin
		#400us;
		bad_count++;
		end_sim();
	end

	// ==================================================================
	// Main sequence
	initial
	begin
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		repeat (6) @(negedge clock);
		chk_word({11'h000, config_out.dcs_enable}, 12'h001);
		chk_word({10'h000, config_out.vref_select}, 12'h003);
		chk_word({10'h000, config_out.power}, {10'h000, PWR_NORMAL});
		chk_word({11'h000, output_data_clock}, 12'h001);
		for (int i = 0; i < 12; i++)
			rd_chk(ra[i], rv[i]);
		wr(ADDR_PART_ID, 8'hff);
		wr(13'h003, 8'hff);
		rd_chk(ADDR_PART_ID, 8'h5a);
		rd_chk(13'h003, 8'h00);
		wr(ADDR_CLOCK, 8'hfe);
		rd_chk(ADDR_CLOCK, 8'h00);
		chk_word({11'h000, config_out.dcs_enable}, 12'h001);
		commit();
		chk_word({11'h000, config_out.dcs_enable}, 12'h000);
		rd_chk(ADDR_TRANSFER, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_MODES, i[7:0]);
			commit();
			chk_word({10'h000, config_out.power}, {10'h000, pexp[i]});
		end
		@(negedge clock);
		power_down_pin = 1'b1;
		// Three sync stages, agreement flop, then the config register
		repeat (6) @(negedge clock);
		chk_word({10'h000, config_out.power}, {10'h000, PWR_OFF});
		wr(ADDR_MODES, 8'h20);
		commit();
		chk_word({10'h000, config_out.power}, {10'h000, PWR_STANDBY});
		power_down_pin = 1'b0;
		wr(ADDR_OFFSET, 8'hff);
		rd_chk(ADDR_OFFSET, 8'h3f);
		wr(ADDR_OFFSET, 8'h20);
		commit();
		conv(14'h2000, 12'h7f8);
		conv(14'h0010, 12'h000);
		wr(ADDR_OFFSET, 8'h1f);
		commit();
		conv(14'h2000, 12'h807);
		conv(14'h3ff0, 12'hfff);
		wr(ADDR_OFFSET, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_TEST, 8'(i + 1));
			commit();
			conv(14'h1234, texp[i]);
		end
		wr(ADDR_TEST, 8'h00);
		wr(ADDR_OUT_MODE, 8'h55);
		commit();
		rd_chk(ADDR_OUT_MODE, 8'h55);
		conv(14'h2000, 12'hfff);
		chk_word({11'h000, output_enable}, 12'h000);
		chk_word({10'h000, config_out.drive_strength}, 12'h001);
		// Eight conversions so far leave the checker phase at its start
		wr(ADDR_TEST, 8'h04);
		commit();
		conv(14'h1234, PAT_CHECK_A);
		conv(14'h1234, PAT_CHECK_B);
		wr(ADDR_OUT_PHASE, 8'h80);
		wr(ADDR_VREF, 8'h40);
		commit();
		chk_word({11'h000, config_out.dco_invert}, 12'h001);
		chk_word({11'h000, output_data_clock}, 12'h000);
		chk_word({10'h000, config_out.vref_select}, 12'h001);
		wr(ADDR_PORT_CFG, 8'h5a);
		host.lsb_first = 1'b1;
		rd_chk(ADDR_PORT_CFG, 8'h5a);
		rd_chk(ADDR_PART_ID, 8'h5a);
		wr(ADDR_PORT_CFG, 8'h3c);
		host.lsb_first = 1'b0;
		repeat (20) @(negedge clock);
		rd_chk(ADDR_PORT_CFG, 8'h18);
		rd_chk(ADDR_CLOCK, 8'h01);
		chk_word({11'h000, config_out.dcs_enable}, 12'h001);
		end_sim();
	end
endmodule : adc_serial_config_tb
